// file: logic/tss_top.sv
// Touch scan sequencer with its serial register port
`timescale 1ns/1ps

// How it works
// - Self mode: touch pulls pen interrupt low and starts conversion clock together.
// - Scan enables vertical drivers, waits settle time, then powers converter, converts.
// - With averaging, several conversions; vertical register written only when done.
// - After vertical store, check touch; only if touched convert horizontal axis.
// - Axis-only scan ends after storing the horizontal result.
// - Pressure scan continues with two pressure conversions into their two registers.
// - Host-started mode: touch alone never starts; the scan-select write does.
// - Axis scan time: 2.5us, twice settle+precharge+sense, 2*avg conversions.
// - Pressure scan: 4.75us, thrice the intervals, four times avg conversions.
// - Single host conversion: 2.125us plus settle plus avg conversions, 2*avg for pressure; temperature 2.625us, no settle.
// - Results right-justified twelve bits, top four bits read zero.
// - Contrast code taken from bits seven to zero; upper byte ignored.
// - Differential temperature: second conversion, own register, 91x bias current.
// - Soft reset register with upper byte BB restores all defaults; else nothing.
// - Between axis conversions wait the programmed sense interval to check touch.
// - Before sensing touch allow the programmed precharge interval.
module tss_top
  import tss_pkg::*;
#(
  parameter logic [7:0][15:0] PRE_CYCLES = TSS_PRE_CYCLES,
  parameter logic [7:0][15:0] SNS_CYCLES = TSS_SNS_CYCLES,
  parameter logic [7:0][15:0] PVS_CYCLES = TSS_PVS_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic touch_sense,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic pen_touch_irq_n,
  output logic conv_clk_en,
  output logic adc_power,
  output logic adc_start,
  output tss_drive_t panel_drive,
  output logic temp_bias_high,
  output logic [7:0] contrast_dac_code
);

  // ****************************************************************
  // Serial port
  // ****************************************************************
  logic sclk_q;
  logic [5:0] bit_cnt;
  logic [15:0] shift_in;
  logic [15:0] tx;
  tss_cmd_t cmd;
  wire sclk_rise = spi_sclk & ~sclk_q & ~spi_cs_n;
  wire sclk_fall = ~spi_sclk & sclk_q & ~spi_cs_n;
  wire [15:0] word_in = {shift_in[14:0], spi_mosi};
  wire cmd_done = sclk_rise && bit_cnt == 6'd15;
  wire tss_cmd_t cmd_new = word_in;
  wire wr_pulse = sclk_rise && bit_cnt == 6'd31 && !cmd.rd;
  wire wr_ctrl = wr_pulse && cmd.page == TSS_PAGE_CTRL;
  wire wr_adc_ctrl = wr_ctrl && cmd.addr == TSS_ADDR_ADC_CTRL;
  wire wr_config = wr_ctrl && cmd.addr == TSS_ADDR_CONFIG;
  wire wr_dac = wr_pulse && cmd.page == TSS_PAGE_DATA && cmd.addr == TSS_ADDR_DAC;
  wire soft_rst = wr_ctrl && cmd.addr == TSS_ADDR_SOFT_RESET
                  && word_in[15:8] == TSS_SOFT_RESET_CODE;
  wire rst_all = rst | soft_rst;

  always_ff @(posedge clk)
  begin
    sclk_q <= rst ? 1'b0 : spi_sclk;
  end

  always_ff @(posedge clk)
  begin
    if (rst || spi_cs_n)
    begin
      bit_cnt <= 6'h00;
      shift_in <= 16'h0000;
      cmd <= '0;
    end
    else if (sclk_rise && bit_cnt != 6'd32)
    begin
      bit_cnt <= bit_cnt + 6'd1;
      shift_in <= word_in;
      if (cmd_done)
        cmd <= cmd_new;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] adc_ctrl;
  logic [15:0] config_reg;
  logic [11:0] result [0:5];
  wire [1:0] mode = adc_ctrl[TSS_MODE_LSB +: 2];
  wire [3:0] func = adc_ctrl[TSS_FUNC_LSB +: 4];
  wire [1:0] avg_sel = adc_ctrl[TSS_AVG_LSB +: 2];
  wire [2:0] pvs_sel = config_reg[TSS_PVS_LSB +: 3];
  wire [2:0] pre_sel = config_reg[TSS_PRE_LSB +: 3];
  wire [2:0] sns_sel = config_reg[TSS_SNS_LSB +: 3];

  wire rd_res = cmd_new.page == TSS_PAGE_DATA && cmd_new.addr <= TSS_ADDR_RES_TOP;
  wire [2:0] rd_slot = cmd_new.addr[2:0];
  wire [15:0] rd_data =
    rd_res ? {4'h0, result[rd_slot]} :
    (cmd_new.page == TSS_PAGE_DATA && cmd_new.addr == TSS_ADDR_DAC) ?
      {8'h00, contrast_dac_code} :
    (cmd_new.page == TSS_PAGE_DATA && cmd_new.addr == TSS_ADDR_ZERO) ? 16'h0000 :
    (cmd_new.page == TSS_PAGE_CTRL && cmd_new.addr == TSS_ADDR_ADC_CTRL) ? adc_ctrl :
    (cmd_new.page == TSS_PAGE_CTRL && cmd_new.addr == TSS_ADDR_CONFIG) ? config_reg :
    TSS_READ_UNMAPPED;

  // Read data goes out on falling edges once the command word is in
  always_ff @(posedge clk)
  begin
    if (rst || spi_cs_n)
    begin
      tx <= 16'h0000;
      spi_miso <= 1'b0;
    end
    else if (cmd_done)
      tx <= cmd_new.rd ? rd_data : 16'h0000;
    else if (sclk_fall && bit_cnt >= 6'd16 && bit_cnt != 6'd32)
    begin
      spi_miso <= tx[15];
      tx <= {tx[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      adc_ctrl <= TSS_ADC_CTRL_RST;
      config_reg <= TSS_CONFIG_RST;
      contrast_dac_code <= TSS_DAC_RST;
    end
    else
    begin
      if (wr_adc_ctrl)
        adc_ctrl <= word_in;
      if (wr_config)
        config_reg <= word_in;
      if (wr_dac)
        contrast_dac_code <= word_in[7:0];
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  tss_state_t state;
  tss_state_t next_state;
  tss_seq_t seq;
  logic [2:0] phase;
  logic [15:0] cnt;
  logic [15:0] acc;
  logic [4:0] conv_n;
  tss_drive_t drive_hold;

  wire [3:0] avg_shift = (avg_sel == 2'h0) ? 4'd0 : {2'b00, avg_sel} + 4'd1;
  wire [4:0] avg_count = 5'(5'd1 << avg_shift);
  wire [3:0] wfn = word_in[TSS_FUNC_LSB +: 4];
  wire [1:0] wmode = word_in[TSS_MODE_LSB +: 2];
  wire w_scan = wfn == TSS_FN_SCAN_XY || wfn == TSS_FN_SCAN_XYZ;
  wire w_conv = wfn == TSS_FN_CONV_X || wfn == TSS_FN_CONV_Y || wfn == TSS_FN_CONV_Z;
  wire w_temp = wfn == TSS_FN_TEMP_SINGLE || wfn == TSS_FN_TEMP_HIGH;
  wire self_go = mode == TSS_MODE_SELF && touch_sense
                 && (func == TSS_FN_SCAN_XY || func == TSS_FN_SCAN_XYZ);
  wire host_scan = wr_adc_ctrl && wmode == TSS_MODE_HOST_START && w_scan;
  wire host_single = wr_adc_ctrl && wmode != TSS_MODE_SELF && (w_conv || w_temp);
  wire start = state == TSS_IDLE && (self_go || host_scan || host_single);
  wire [3:0] start_fn = self_go ? func : wfn;
  wire is_temp = phase == TSS_PH_T1 || phase == TSS_PH_T2;
  wire cnt_zero = cnt == 16'h0000;
  wire last_conv = conv_n == avg_count;

  wire [2:0] start_phase =
    (start_fn == TSS_FN_CONV_X) ? TSS_PH_X :
    (start_fn == TSS_FN_CONV_Z) ? TSS_PH_Z1 :
    (start_fn == TSS_FN_TEMP_SINGLE) ? TSS_PH_T1 :
    (start_fn == TSS_FN_TEMP_HIGH) ? TSS_PH_T2 : TSS_PH_Y;
  wire tss_seq_t start_seq =
    (start_fn == TSS_FN_SCAN_XY) ? TSS_SEQ_XY :
    (start_fn == TSS_FN_SCAN_XYZ) ? TSS_SEQ_XYZ : TSS_SEQ_SINGLE;
  // Fixed overhead is paid once at the start of each sequence
  wire [15:0] ovh_cyc =
    (start_seq == TSS_SEQ_XY) ? TSS_OVH_XY_CYC :
    (start_seq == TSS_SEQ_XYZ) ? TSS_OVH_XYZ_CYC :
    (start_phase >= TSS_PH_T1) ? TSS_OVH_TEMP_CYC : TSS_OVH_HOST_CYC;
  wire [2:0] after_check = (phase == TSS_PH_Y) ? TSS_PH_X : TSS_PH_Z1;
  wire check_done = !touch_sense || phase == TSS_PH_Z2
                    || (phase == TSS_PH_X && seq == TSS_SEQ_XY);

  always_comb
  begin
    next_state = state;
    case (state)
      TSS_IDLE:
        if (start)
          next_state = TSS_OVH;
      TSS_OVH:
        if (cnt_zero)
          next_state = is_temp ? TSS_CONV : TSS_SETTLE;
      TSS_SETTLE:
        if (cnt_zero)
          next_state = TSS_CONV;
      TSS_CONV:
        next_state = TSS_WAIT;
      TSS_WAIT:
        if (adc_done)
          next_state = TSS_GAP;
      TSS_GAP:
        if (cnt_zero)
          next_state = last_conv ? TSS_STORE : TSS_CONV;
      TSS_STORE:
        if (phase == TSS_PH_Z1)
          next_state = TSS_CONV;
        else if (seq == TSS_SEQ_SINGLE)
          next_state = TSS_IDLE;
        else
          next_state = TSS_PRECH;
      TSS_PRECH:
        if (cnt_zero)
          next_state = TSS_SENSE;
      TSS_SENSE:
        if (cnt_zero)
          next_state = TSS_CHECK;
      TSS_CHECK:
        next_state = check_done ? TSS_IDLE : TSS_SETTLE;
      default:
        next_state = TSS_IDLE;
    endcase
  end

  // Timed states run for their load value plus one cycle
  wire [15:0] load_val =
    (next_state == TSS_OVH) ? ovh_cyc - 16'd1 :
    (next_state == TSS_SETTLE) ? PVS_CYCLES[pvs_sel] - 16'd1 :
    (next_state == TSS_GAP) ? TSS_CONV_GAP_CYC - 16'd1 :
    (next_state == TSS_PRECH) ? PRE_CYCLES[pre_sel] - 16'd1 :
    (next_state == TSS_SENSE) ? SNS_CYCLES[sns_sel] - 16'd1 : 16'h0000;
  wire [15:0] next_acc = acc + {4'h0, adc_data};
  wire [15:0] avg_val = acc >> avg_shift;

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      state <= TSS_IDLE;
      cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt <= (next_state != state) ? load_val : cnt - 16'd1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      seq <= TSS_SEQ_XY;
      phase <= TSS_PH_Y;
      acc <= 16'h0000;
      conv_n <= 5'd0;
    end
    else if (start)
    begin
      seq <= start_seq;
      phase <= start_phase;
      acc <= 16'h0000;
      conv_n <= 5'd0;
    end
    else if (state == TSS_WAIT && adc_done)
    begin
      acc <= next_acc;
      conv_n <= conv_n + 5'd1;
    end
    else if (state == TSS_STORE)
    begin
      acc <= 16'h0000;
      conv_n <= 5'd0;
      if (phase == TSS_PH_Z1)
        phase <= TSS_PH_Z2;
    end
    else if (state == TSS_CHECK && !check_done)
      phase <= after_check;
  end

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      for (int i = 0; i < 6; i++)
        result[i] <= 12'h000;
    end
    else if (state == TSS_STORE)
      result[phase] <= avg_val[11:0];
  end

  // Held drivers let the host settle the panel before asking for a conversion
  always_ff @(posedge clk)
  begin
    if (rst_all)
      drive_hold <= '0;
    else if (wr_adc_ctrl && wmode == TSS_MODE_HOST_CTRL)
    begin
      drive_hold.x <= wfn == TSS_FN_DRIVE_X;
      drive_hold.y <= wfn == TSS_FN_DRIVE_Y;
      drive_hold.z <= wfn == TSS_FN_DRIVE_Z;
    end
  end

  // ****************************************************************
  // Analog controls
  // ****************************************************************
  wire busy = state != TSS_IDLE;
  wire next_busy = next_state != TSS_IDLE;
  wire panel_phase = next_busy && next_state != TSS_OVH && next_state != TSS_PRECH
                     && next_state != TSS_SENSE && next_state != TSS_CHECK;
  wire converting = next_state == TSS_CONV || next_state == TSS_WAIT
                    || next_state == TSS_GAP;
  wire [2:0] next_phase = start ? start_phase
                        : (state == TSS_STORE && phase == TSS_PH_Z1) ? TSS_PH_Z2
                        : (state == TSS_CHECK) ? after_check : phase;
  wire next_temp = next_phase == TSS_PH_T1 || next_phase == TSS_PH_T2;
  wire tss_drive_t next_drive = drive_hold | ((panel_phase && !next_temp) ? tss_drive_t'{
    x: next_phase == TSS_PH_X, y: next_phase == TSS_PH_Y,
    z: next_phase == TSS_PH_Z1 || next_phase == TSS_PH_Z2} : '0);
  // Interrupt stays asserted through an automatic scan; once idle it follows the touch input
  wire next_irq_n = ~((!busy && touch_sense) || (next_busy && start_seq != TSS_SEQ_SINGLE
                      && (start || seq != TSS_SEQ_SINGLE)));

  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      pen_touch_irq_n <= 1'b1;
      conv_clk_en <= 1'b0;
      adc_power <= 1'b0;
      adc_start <= 1'b0;
      panel_drive <= '0;
      temp_bias_high <= 1'b0;
    end
    else
    begin
      pen_touch_irq_n <= next_irq_n;
      conv_clk_en <= next_busy;
      adc_power <= converting;
      adc_start <= next_state == TSS_CONV;
      panel_drive <= next_drive;
      temp_bias_high <= next_busy && next_phase == TSS_PH_T2;
    end
  end

endmodule

// file: logic/tss_pkg.sv
// Constants, field layouts and carrier types of the touch scan sequencer
package tss_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int TSS_CLK_NS = 100;

  // Least times round up, never below one cycle
  function automatic logic [15:0] tss_cyc_up(input int ns);
    int c;
    c = (ns + TSS_CLK_NS - 1) / TSS_CLK_NS;
    return (c < 1) ? 16'h0001 : 16'(c);
  endfunction

  localparam int TSS_OVH_XY_NS = 2500;
  localparam int TSS_OVH_XYZ_NS = 4750;
  localparam int TSS_OVH_HOST_NS = 2125;
  localparam int TSS_OVH_TEMP_NS = 2625;
  localparam int TSS_CONV_GAP_NS = 4400;
  localparam logic [15:0] TSS_OVH_XY_CYC = tss_cyc_up(TSS_OVH_XY_NS);
  localparam logic [15:0] TSS_OVH_XYZ_CYC = tss_cyc_up(TSS_OVH_XYZ_NS);
  localparam logic [15:0] TSS_OVH_HOST_CYC = tss_cyc_up(TSS_OVH_HOST_NS);
  localparam logic [15:0] TSS_OVH_TEMP_CYC = tss_cyc_up(TSS_OVH_TEMP_NS);
  localparam logic [15:0] TSS_CONV_GAP_CYC = tss_cyc_up(TSS_CONV_GAP_NS);

  // Selectable intervals, index 7 first
  localparam logic [7:0][15:0] TSS_PRE_CYCLES = {
    tss_cyc_up(1364000), tss_cyc_up(1300000), tss_cyc_up(1108000), tss_cyc_up(1044000),
    tss_cyc_up(340000), tss_cyc_up(276000), tss_cyc_up(84000), tss_cyc_up(20000)};
  localparam logic [7:0][15:0] TSS_SNS_CYCLES = {
    tss_cyc_up(2656000), tss_cyc_up(2592000), tss_cyc_up(2144000), tss_cyc_up(2080000),
    tss_cyc_up(608000), tss_cyc_up(544000), tss_cyc_up(96000), tss_cyc_up(32000)};
  localparam logic [7:0][15:0] TSS_PVS_CYCLES = {
    tss_cyc_up(2000000), tss_cyc_up(1000000), tss_cyc_up(500000), tss_cyc_up(200000),
    tss_cyc_up(100000), tss_cyc_up(50000), tss_cyc_up(10000), tss_cyc_up(2000)};

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] TSS_PAGE_DATA = 4'h0;
  localparam logic [3:0] TSS_PAGE_CTRL = 4'h1;
  localparam logic [5:0] TSS_ADDR_RES_Y = 6'h00;
  localparam logic [5:0] TSS_ADDR_RES_TOP = 6'h05;
  localparam logic [5:0] TSS_ADDR_DAC = 6'h0B;
  localparam logic [5:0] TSS_ADDR_ZERO = 6'h10;
  localparam logic [5:0] TSS_ADDR_ADC_CTRL = 6'h00;
  localparam logic [5:0] TSS_ADDR_SOFT_RESET = 6'h04;
  localparam logic [5:0] TSS_ADDR_CONFIG = 6'h05;
  localparam logic [7:0] TSS_SOFT_RESET_CODE = 8'hBB;
  localparam logic [15:0] TSS_READ_UNMAPPED = 16'hFFFF;
  localparam logic [15:0] TSS_ADC_CTRL_RST = 16'h0000;
  localparam logic [15:0] TSS_CONFIG_RST = 16'h0000;
  localparam logic [7:0] TSS_DAC_RST = 8'h80;

  // Control register fields
  localparam int TSS_MODE_LSB = 14;
  localparam int TSS_FUNC_LSB = 10;
  localparam int TSS_AVG_LSB = 8;
  localparam int TSS_PVS_LSB = 6;
  localparam int TSS_PRE_LSB = 3;
  localparam int TSS_SNS_LSB = 0;

  localparam logic [1:0] TSS_MODE_SELF = 2'h0;
  localparam logic [1:0] TSS_MODE_HOST_START = 2'h1;
  localparam logic [1:0] TSS_MODE_HOST_CTRL = 2'h2;

  localparam logic [3:0] TSS_FN_SCAN_XY = 4'h0;
  localparam logic [3:0] TSS_FN_SCAN_XYZ = 4'h1;
  localparam logic [3:0] TSS_FN_CONV_X = 4'h2;
  localparam logic [3:0] TSS_FN_CONV_Y = 4'h3;
  localparam logic [3:0] TSS_FN_CONV_Z = 4'h4;
  localparam logic [3:0] TSS_FN_DRIVE_X = 4'h5;
  localparam logic [3:0] TSS_FN_DRIVE_Y = 4'h6;
  localparam logic [3:0] TSS_FN_DRIVE_Z = 4'h7;
  localparam logic [3:0] TSS_FN_TEMP_SINGLE = 4'h8;
  localparam logic [3:0] TSS_FN_TEMP_HIGH = 4'h9;

  // Result slots, also the scan phase
  localparam logic [2:0] TSS_PH_Y = 3'h0;
  localparam logic [2:0] TSS_PH_X = 3'h1;
  localparam logic [2:0] TSS_PH_Z1 = 3'h2;
  localparam logic [2:0] TSS_PH_Z2 = 3'h3;
  localparam logic [2:0] TSS_PH_T1 = 3'h4;
  localparam logic [2:0] TSS_PH_T2 = 3'h5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    TSS_IDLE = 4'h0, TSS_OVH = 4'h1, TSS_SETTLE = 4'h2, TSS_CONV = 4'h3, TSS_WAIT = 4'h4,
    TSS_GAP = 4'h5, TSS_STORE = 4'h6, TSS_PRECH = 4'h7, TSS_SENSE = 4'h8, TSS_CHECK = 4'h9
  } tss_state_t;

  typedef enum logic [1:0] {
    TSS_SEQ_XY = 2'h0, TSS_SEQ_XYZ = 2'h1, TSS_SEQ_SINGLE = 2'h2
  } tss_seq_t;

  typedef struct packed {
    logic rd;
    logic [3:0] page;
    logic [5:0] addr;
    logic [4:0] spare;
  } tss_cmd_t;

  typedef struct packed {
    logic x;
    logic y;
    logic z;
  } tss_drive_t;

endpackage

// file: bench/tss_top_asserts.sv
// Port-level timing checks for the touch scan sequencer
`timescale 1ns/1ps
module tss_top_asserts
  import tss_pkg::*;
#(
  parameter logic [7:0][15:0] PRE_CYCLES = TSS_PRE_CYCLES,
  parameter logic [7:0][15:0] SNS_CYCLES = TSS_SNS_CYCLES,
  parameter logic [7:0][15:0] PVS_CYCLES = TSS_PVS_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic touch_sense,
  input wire logic adc_done,
  input wire logic pen_touch_irq_n,
  input wire logic conv_clk_en,
  input wire logic adc_power,
  input wire logic adc_start,
  input wire tss_drive_t panel_drive,
  input wire logic temp_bias_high
);
  // Shortest entry, so the bounds hold whatever interval is selected
  function automatic int tmin(input logic [7:0][15:0] t);
    int m;
    m = int'(t[0]);
    for (int i = 1; i < 8; i++)
      m = (t[i] < m) ? int'(t[i]) : m;
    return m;
  endfunction
  localparam int GAP_MIN = int'(TSS_CONV_GAP_CYC) - 1;
  localparam int SETTLE_MIN = tmin(PVS_CYCLES) - 1;
  localparam int SENSE_MIN = int'(TSS_CONV_GAP_CYC) + tmin(PRE_CYCLES) + tmin(SNS_CYCLES) - 1;
  logic [15:0] since_done;
  logic [15:0] drv_age;
  tss_drive_t last_drive;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      since_done <= 16'hFFFF;
      drv_age <= 16'h0000;
      last_drive <= 3'h0;
    end
    else
    begin
      since_done <= adc_done ? 16'h0000 : since_done + 16'(since_done != 16'hFFFF);
      drv_age <= (panel_drive != last_drive) ? 16'h0000 : drv_age + 16'(drv_age != 16'hFFFF);
      last_drive <= panel_drive;
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_touch_irq;
    touch_sense && !conv_clk_en |=> !pen_touch_irq_n;
  endproperty
  a_touch_irq: assert property (p_touch_irq) else $error("no pen irq on touch");
  property p_power_clock;
    adc_power |-> conv_clk_en;
  endproperty
  a_power_clock: assert property (p_power_clock) else $error("power without clock");
  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_start_powered;
    adc_start |-> adc_power;
  endproperty
  a_start_powered: assert property (p_start_powered) else $error("start unpowered");
  property p_conv_gap;
    adc_start |-> since_done >= 16'(GAP_MIN);
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversion gap short");
  property p_settle;
    $rose(adc_power) && panel_drive != 3'h0 |-> drv_age >= 16'(SETTLE_MIN);
  endproperty
  a_settle: assert property (p_settle) else $error("settle time short");
  property p_sense_wait;
    $rose(panel_drive.x) && conv_clk_en |-> since_done >= 16'(SENSE_MIN);
  endproperty
  a_sense_wait: assert property (p_sense_wait) else $error("sense wait short");
  property p_end_quiet;
    $fell(conv_clk_en) |-> !adc_power && !adc_start;
  endproperty
  a_end_quiet: assert property (p_end_quiet) else $error("end leaves power");
  property p_bias_alone;
    temp_bias_high |-> panel_drive == 3'h0;
  endproperty
  a_bias_alone: assert property (p_bias_alone) else $error("bias with drivers");
  c_x_phase: cover property ($rose(panel_drive.x) && conv_clk_en);
  c_scan_end: cover property ($fell(conv_clk_en));
  c_high_bias: cover property (temp_bias_high && adc_start);
endmodule

bind tss_top tss_top_asserts #(.PRE_CYCLES(PRE_CYCLES), .SNS_CYCLES(SNS_CYCLES),
  .PVS_CYCLES(PVS_CYCLES)) tss_top_asserts_inst (.clk(clk), .rst(rst),
  .touch_sense(touch_sense), .adc_done(adc_done), .pen_touch_irq_n(pen_touch_irq_n),
  .conv_clk_en(conv_clk_en), .adc_power(adc_power), .adc_start(adc_start),
  .panel_drive(panel_drive), .temp_bias_high(temp_bias_high));

// file: bench/tss_host_model.sv
// Host processor model driving the serial register link
`timescale 1ns/1ps
module tss_host_model (
  input wire logic clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // One command and one data word per frame; the bench orders the steps
  // Five-clock half periods leave room for the sampled clock and data delay
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      spi_mosi <= sh[i];
      repeat (5) @(posedge clk);
      spi_sclk <= 1'b1;
      if (i < 16)
        rd[i] = spi_miso;
      repeat (5) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    spi_cs_n <= 1'b1;
    // A released line must not keep showing the last bit
    spi_mosi <= ~spi_mosi;
    repeat (2) @(posedge clk);
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the touch scan sequencer
`timescale 1ns/1ps
module testbench;
  import tss_pkg::*;
  localparam logic [7:0][15:0] SHORT = {8{16'h0003}};
  logic clk, rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, touch_sense;
  logic adc_done = 1'b0;
  logic zsel = 1'b0;
  logic pen_touch_irq_n, conv_clk_en, adc_power, adc_start, temp_bias_high;
  logic [11:0] adc_data = 12'h000;
  logic [11:0] d;
  logic [11:0] expv [6];
  logic [7:0] contrast_dac_code;
  logic [15:0] w;
  tss_drive_t panel_drive;
  int fail_count, total_checks, cyc, average_count, ashift, nstart, nbias, ph, dly, n, k, tcyc, tfirst;
  int acc [6], cnt [6], nst [6];
  logic [3:0] fns [5] = '{TSS_FN_CONV_X, TSS_FN_CONV_Y, TSS_FN_CONV_Z, TSS_FN_TEMP_SINGLE,
    TSS_FN_TEMP_HIGH};
  int rp [5] = '{1, 0, 2, 4, 5};
  logic [2:0] drv [5] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
  tss_top #(.PRE_CYCLES(SHORT), .SNS_CYCLES(SHORT), .PVS_CYCLES(SHORT)) tss_top_inst (
    .clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .touch_sense(touch_sense), .adc_done(adc_done), .adc_data(adc_data),
    .pen_touch_irq_n(pen_touch_irq_n), .conv_clk_en(conv_clk_en), .adc_power(adc_power),
    .adc_start(adc_start), .panel_drive(panel_drive), .temp_bias_high(temp_bias_high),
    .contrast_dac_code(contrast_dac_code));
  tss_host_model tss_host_model_inst (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ********
  // Converter model: result slot from the drivers, averaged as programmed
  // ********
  always @(posedge clk)
  begin
    adc_done <= 1'b0;
    // Cycles since the conversion clock started; first start of each sequence kept
    tcyc = (conv_clk_en === 1'b1) ? tcyc + 1 : 0;
    tfirst = (tcyc == 1) ? 0 : tfirst;
    if (adc_start === 1'b1)
    begin
      nstart++;
      tfirst = (tfirst == 0) ? tcyc : tfirst;
      nbias += int'(temp_bias_high);
      ph = panel_drive.y ? 0 : panel_drive.x ? 1 : panel_drive.z ? (zsel ? 3 : 2) :
        (temp_bias_high ? 5 : 4);
      dly = 3;
    end
    else if (dly > 0)
    begin
      dly--;
      if (dly == 0)
      begin
        d = 12'($urandom);
        adc_done <= 1'b1;
        adc_data <= d;
        acc[ph] += int'(d);
        cnt[ph]++;
        if (cnt[ph] == average_count)
        begin
          expv[ph] = 12'(acc[ph] >> ashift);
          acc[ph] = 0;
          cnt[ph] = 0;
          nst[ph]++;
          zsel = (ph == 2) ? 1'b1 : (ph == 3) ? 1'b0 : zsel;
        end
      end
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] pg, input logic [5:0] a, input logic [15:0] wd);
    logic [15:0] r;
    tss_host_model_inst.xfer({1'b0, pg, a, 5'h00}, wd, r);
  endtask
  task automatic rchk(input logic [3:0] pg, input logic [5:0] a, input logic [15:0] want);
    logic [15:0] r;
    tss_host_model_inst.xfer({1'b1, pg, a, 5'h00}, 16'h0000, r);
    chk(r, want);
  endtask
  // Averages of 1, 4, 8, 16 divide by shifting
  task automatic set_ctrl(input logic [15:0] v);
    ashift = (v[9:8] == 2'h0) ? 0 : int'(v[9:8]) + 1;
    average_count = 1 << ashift;
    wr(TSS_PAGE_CTRL, TSS_ADDR_ADC_CTRL, v);
  endtask
  task automatic wait_idle;
    n = 0;
    repeat (2) @(posedge clk);
    while (conv_clk_en !== 1'b0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    chk(16'(conv_clk_en), 16'h0000);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    touch_sense = 1'b0;
    void'($urandom(32'hC8A3));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(16'(contrast_dac_code), 16'(TSS_DAC_RST));
    rchk(TSS_PAGE_CTRL, TSS_ADDR_SOFT_RESET, TSS_READ_UNMAPPED);
    w = 16'($urandom);
    wr(TSS_PAGE_DATA, TSS_ADDR_DAC, w);
    chk(16'(contrast_dac_code), 16'(w[7:0]));
    rchk(TSS_PAGE_DATA, TSS_ADDR_DAC, {8'h00, w[7:0]});
    wr(TSS_PAGE_CTRL, TSS_ADDR_CONFIG, 16'h01FF);
    wr(TSS_PAGE_CTRL, TSS_ADDR_SOFT_RESET, {8'hBA, w[7:0]});
    chk(16'(contrast_dac_code), 16'(w[7:0]));
    wr(TSS_PAGE_CTRL, TSS_ADDR_SOFT_RESET, {TSS_SOFT_RESET_CODE, w[15:8]});
    chk(16'(contrast_dac_code), 16'(TSS_DAC_RST));
    rchk(TSS_PAGE_CTRL, TSS_ADDR_CONFIG, TSS_CONFIG_RST);
    // Self-started axis scan with four averages
    set_ctrl(16'h0100);
    touch_sense <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'({pen_touch_irq_n, conv_clk_en}), 16'h0001);
    n = 0;
    while (nst[1] == 0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    touch_sense <= 1'b0;
    wait_idle();
    rchk(TSS_PAGE_DATA, 6'h00, {4'h0, expv[0]});
    rchk(TSS_PAGE_DATA, 6'h01, {4'h0, expv[1]});
    chk(16'(nst[2]), 16'h0000);
    // Host-started scan with the panel released: abandoned after the vertical axis
    set_ctrl(16'h4000);
    wait_idle();
    chk(16'(nst[1]), 16'h0001);
    chk(16'({adc_power, 1'b0, panel_drive}), 16'h0000);
    rchk(TSS_PAGE_DATA, 6'h00, {4'h0, expv[0]});
    touch_sense <= 1'b1;
    k = nstart;
    repeat (100) @(posedge clk);
    chk(16'(nstart - k), 16'h0000);
    chk(16'(pen_touch_irq_n), 16'h0000);
    set_ctrl(16'h4400);
    wait_idle();
    touch_sense <= 1'b0;
    for (int i = 0; i < 4; i++)
      rchk(TSS_PAGE_DATA, 6'(i), {4'h0, expv[i]});
    chk(16'(nst[3]), 16'h0001);
    // Host-controlled single conversions and both temperature modes
    for (int i = 0; i < 5; i++)
    begin
      if (fns[i] < TSS_FN_TEMP_SINGLE)
      begin
        set_ctrl({TSS_MODE_HOST_CTRL, fns[i] + 4'h3, 10'h000});
        chk(16'(panel_drive), 16'(drv[i]));
        repeat (4) @(posedge clk);
      end
      k = nbias;
      set_ctrl({TSS_MODE_HOST_CTRL, fns[i], 10'h000});
      wait_idle();
      chk(16'(nbias - k), 16'(fns[i] == TSS_FN_TEMP_HIGH));
      // Overhead plus settle before the first start; temperature skips the settle
      n = (fns[i] < TSS_FN_TEMP_SINGLE) ? int'(TSS_OVH_HOST_CYC) + int'(SHORT[0])
        : int'(TSS_OVH_TEMP_CYC);
      chk(16'(tfirst), 16'(n + 1));
      rchk(TSS_PAGE_DATA, 6'(rp[i]), {4'h0, expv[rp[i]]});
      if (fns[i] == TSS_FN_CONV_Z)
        rchk(TSS_PAGE_DATA, 6'h03, {4'h0, expv[3]});
    end
    tally_and_finish();
  end
endmodule
